// [dmadc_top.sv]
// dma descriptor channel engine with apb register slave and one memory master port
// assumes memory answers a held mem_req with a one-cycle mem_ack, one request at a time
`timescale 1ns/100ps
module dmadc_top import dmadc_pkg::*; #(
    parameter int NCH = 12
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [1:0] mem_size,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_rdata,
    output logic [NCH-1:0] evt_strobe,
    output logic [NCH-1:0] busy_channel_map,
    output logic irq
);
    localparam logic [NCH-1:0] NONE = '0;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // ==========================================================
    // helpers
    function automatic logic [NCH-1:0] onehot(input logic [3:0] ch);
        onehot = NONE;
        onehot[ch] = 1'b1;
    endfunction : onehot

    function automatic logic [31:0] ch_addr(input logic [31:0] base, input logic [3:0] ch);
        ch_addr = base + CH_STRIDE * {28'h0, ch};
    endfunction : ch_addr

    function automatic logic [31:0] beat_bytes(input logic [1:0] sz);
        beat_bytes = 32'h1 << sz;
    endfunction : beat_bytes

    function automatic logic [NCH-1:0] w1c(input logic [NCH-1:0] f, input logic hit,
                                           input logic [31:0] d, input logic [NCH-1:0] s);
        // the hardware set wins over a same-cycle clear
        w1c = (hit ? (f & ~d[NCH-1:0]) : f) | s;
    endfunction : w1c

    // ==========================================================
    // registers
    dmadc_state_t st_reg;
    logic [31:0] prdata_reg, mem_addr_reg, mem_wdata_reg;
    logic pready_reg, pslverr_reg, mem_req_reg, mem_we_reg, irq_reg;
    logic [1:0] mem_size_reg, wcnt_reg;
    logic [NCH-1:0] en_reg, susp_reg, done_flg_reg, err_flg_reg, susp_flg_reg;
    logic [NCH-1:0] done_msk_reg, err_msk_reg, susp_msk_reg, pend_reg, busy_reg, evt_reg;
    logic [NCH-1:0] use_ptr_reg, use_wb_reg;
    logic [31:0] desc_base_reg, wb_base_reg, src_reg, dst_reg, nxt_reg, data_reg, daddr_reg;
    logic [31:0] rptr_mem [NCH];
    logic [15:0] ctrl_reg, cnt_reg;
    logic [3:0] cur_reg;
    logic err_reg, ab_reg;

    // ==========================================================
    // apb slave: one wait-free access cycle, data prepared in setup
    logic setup, wr, rd_ok;
    logic [31:0] rd_word;
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & pready_reg;

    always_comb begin
        rd_word = RESET_WORD;
        rd_ok = 1'b1;
        if (paddr == OFF_CH_EN) begin
            rd_word[NCH-1:0] = en_reg;
        end else if (paddr == OFF_SUSPENDED) begin
            rd_word[NCH-1:0] = susp_reg;
        end else if (paddr == OFF_ABORT || paddr == OFF_RESUME) begin
            rd_word = RESET_WORD;
        end else if (paddr == OFF_DONE_FLG) begin
            rd_word[NCH-1:0] = done_flg_reg;
        end else if (paddr == OFF_ERR_FLG) begin
            rd_word[NCH-1:0] = err_flg_reg;
        end else if (paddr == OFF_SUSP_FLG) begin
            rd_word[NCH-1:0] = susp_flg_reg;
        end else if (paddr == OFF_DONE_MSK) begin
            rd_word[NCH-1:0] = done_msk_reg;
        end else if (paddr == OFF_ERR_MSK) begin
            rd_word[NCH-1:0] = err_msk_reg;
        end else if (paddr == OFF_SUSP_MSK) begin
            rd_word[NCH-1:0] = susp_msk_reg;
        end else if (paddr == OFF_IRQ_STATUS) begin
            rd_word[NCH-1:0] = pend_reg;
        end else if (paddr == OFF_BUSY) begin
            rd_word[NCH-1:0] = busy_reg;
        end else if (paddr == OFF_DESC_BASE) begin
            rd_word = desc_base_reg;
        end else if (paddr == OFF_WB_BASE) begin
            rd_word = wb_base_reg;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= RESET_WORD;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~rd_ok;
            prdata_reg <= (setup & ~pwrite) ? rd_word : RESET_WORD;
        end
    end

    // ==========================================================
    // engine events
    logic [1:0] act, evo, bsz;
    logic last, fin, bad_desc;
    logic [NCH-1:0] cur_1h, hw_dis, hw_sus, set_done, set_err, set_susp, want;
    logic [3:0] pick;
    assign act = ctrl_reg[F_ACT +: 2];
    assign evo = ctrl_reg[F_EVO +: 2];
    assign bsz = ctrl_reg[F_BEAT +: 2];
    assign last = (nxt_reg == RESET_WORD);
    assign fin = (st_reg == S_FIN);
    assign cur_1h = onehot(cur_reg);
    assign want = en_reg & ~susp_reg;
    assign bad_desc = (st_reg == S_FETCH) && mem_ack && !mem_err && wcnt_reg == 2'h0
                      && !mem_rdata[F_VALID];

    always_comb begin
        pick = 4'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (want[i]) begin
                pick = 4'(i);
            end
        end
    end

    always_comb begin
        hw_dis = NONE;
        hw_sus = NONE;
        set_done = NONE;
        set_err = NONE;
        if (bad_desc) begin
            hw_sus = cur_1h;
        end
        if (fin) begin
            if (err_reg) begin
                set_err = cur_1h;
                hw_dis = cur_1h;
            end else if (ab_reg) begin
                hw_dis = cur_1h;
            end else begin
                case (act)
                    ACT_NO_ACTION, ACT_INT: begin
                        hw_dis = last ? cur_1h : NONE;
                    end
                    default: begin
                        hw_sus = cur_1h;
                        hw_dis = last ? cur_1h : NONE;
                    end
                endcase
                if (act == ACT_INT || act == ACT_BOTH) begin
                    set_done = cur_1h;
                end
            end
        end
        set_susp = hw_sus;
    end

    // ==========================================================
    // channel control registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            en_reg <= NONE;
            susp_reg <= NONE;
            use_ptr_reg <= NONE;
            use_wb_reg <= NONE;
        end else begin
            if (wr && paddr == OFF_CH_EN) begin
                en_reg <= pwdata[NCH-1:0];
                use_ptr_reg <= use_ptr_reg & en_reg;
                use_wb_reg <= use_wb_reg & en_reg;
            end else if (wr && paddr == OFF_ABORT) begin
                // an active channel stops through write-back instead
                en_reg <= en_reg & ~hw_dis & ~(pwdata[NCH-1:0] & ~busy_reg);
            end else begin
                en_reg <= en_reg & ~hw_dis;
                if (bad_desc) begin
                    use_wb_reg <= use_wb_reg | cur_1h;
                    use_ptr_reg <= use_ptr_reg & ~cur_1h;
                end else if (fin && !last && act[1]) begin
                    use_ptr_reg <= use_ptr_reg | cur_1h;
                end
            end
            susp_reg <= (wr && paddr == OFF_RESUME) ?
                        ((susp_reg & ~pwdata[NCH-1:0]) | hw_sus) : (susp_reg | hw_sus);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (fin && !last && act[1]) begin
            rptr_mem[cur_reg] <= nxt_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            done_msk_reg <= NONE;
            err_msk_reg <= NONE;
            susp_msk_reg <= NONE;
            desc_base_reg <= RESET_WORD;
            wb_base_reg <= RESET_WORD;
        end else if (wr) begin
            if (paddr == OFF_DONE_MSK) begin
                done_msk_reg <= pwdata[NCH-1:0];
            end else if (paddr == OFF_ERR_MSK) begin
                err_msk_reg <= pwdata[NCH-1:0];
            end else if (paddr == OFF_SUSP_MSK) begin
                susp_msk_reg <= pwdata[NCH-1:0];
            end else if (paddr == OFF_DESC_BASE) begin
                desc_base_reg <= pwdata;
            end else if (paddr == OFF_WB_BASE) begin
                wb_base_reg <= pwdata;
            end
        end
    end

    // ==========================================================
    // interrupt flags, pending map and line
    logic [NCH-1:0] pend_next;
    assign pend_next = (done_flg_reg & done_msk_reg) | (err_flg_reg & err_msk_reg)
                       | (susp_flg_reg & susp_msk_reg);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            done_flg_reg <= NONE;
            err_flg_reg <= NONE;
            susp_flg_reg <= NONE;
            pend_reg <= NONE;
            irq_reg <= 1'b0;
        end else begin
            done_flg_reg <= w1c(done_flg_reg, wr && paddr == OFF_DONE_FLG, pwdata, set_done);
            err_flg_reg <= w1c(err_flg_reg, wr && paddr == OFF_ERR_FLG, pwdata, set_err);
            susp_flg_reg <= w1c(susp_flg_reg, wr && paddr == OFF_SUSP_FLG, pwdata, set_susp);
            pend_reg <= pend_next;
            irq_reg <= |pend_next;
        end
    end

    // ==========================================================
    // transfer engine
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= S_IDLE;
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= RESET_WORD;
            mem_wdata_reg <= RESET_WORD;
            mem_size_reg <= BEAT_WORD;
            wcnt_reg <= 2'h0;
            cur_reg <= 4'h0;
            ctrl_reg <= 16'h0;
            cnt_reg <= 16'h0;
            src_reg <= RESET_WORD;
            dst_reg <= RESET_WORD;
            nxt_reg <= RESET_WORD;
            data_reg <= RESET_WORD;
            daddr_reg <= RESET_WORD;
            err_reg <= 1'b0;
            ab_reg <= 1'b0;
        end else begin
            if (wr && paddr == OFF_ABORT && (pwdata[NCH-1:0] & cur_1h & busy_reg) != NONE) begin
                ab_reg <= 1'b1;
            end
            case (st_reg)
                S_IDLE: begin
                    err_reg <= 1'b0;
                    ab_reg <= 1'b0;
                    if (want != NONE) begin
                        cur_reg <= pick;
                        daddr_reg <= use_ptr_reg[pick] ? rptr_mem[pick] :
                            ch_addr(use_wb_reg[pick] ? wb_base_reg : desc_base_reg,
                                    pick);
                        mem_addr_reg <= use_ptr_reg[pick] ? rptr_mem[pick] :
                            ch_addr(use_wb_reg[pick] ? wb_base_reg : desc_base_reg, pick);
                        mem_we_reg <= 1'b0;
                        mem_size_reg <= BEAT_WORD;
                        mem_req_reg <= 1'b1;
                        wcnt_reg <= 2'h0;
                        st_reg <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (mem_ack) begin
                        mem_req_reg <= 1'b0;
                        wcnt_reg <= wcnt_reg + 2'h1;
                        case (wcnt_reg)
                            2'h0: {cnt_reg, ctrl_reg} <= mem_rdata;
                            2'h1: src_reg <= mem_rdata;
                            2'h2: dst_reg <= mem_rdata;
                            default: nxt_reg <= mem_rdata;
                        endcase
                        if (mem_err) begin
                            err_reg <= 1'b1;
                            st_reg <= S_FIN;
                        end else if (bad_desc) begin
                            st_reg <= S_IDLE;
                        end else if (wcnt_reg == W_LAST) begin
                            // an empty or aborted block goes to write-back with no read pending
                            mem_req_reg <= (cnt_reg != 16'h0) && !ab_reg;
                            mem_addr_reg <= src_reg;
                            mem_size_reg <= bsz;
                            st_reg <= (cnt_reg == 16'h0 || ab_reg) ? S_WB : S_RD;
                        end else begin
                            mem_req_reg <= 1'b1;
                            mem_addr_reg <= daddr_reg + ((wcnt_reg == 2'h0) ? DW_SRC :
                                            (wcnt_reg == 2'h1) ? DW_DST : DW_NEXT);
                        end
                    end
                end
                S_RD: begin
                    if (mem_ack) begin
                        data_reg <= mem_rdata;
                        if (ctrl_reg[F_SRCINC]) begin
                            src_reg <= src_reg + beat_bytes(bsz);
                        end
                        mem_req_reg <= !mem_err;
                        mem_we_reg <= 1'b1;
                        mem_addr_reg <= dst_reg;
                        mem_wdata_reg <= mem_rdata;
                        err_reg <= mem_err;
                        st_reg <= mem_err ? S_WB : S_WR;
                    end
                end
                S_WR: begin
                    if (mem_ack) begin
                        if (ctrl_reg[F_DSTINC]) begin
                            dst_reg <= dst_reg + beat_bytes(bsz);
                        end
                        cnt_reg <= cnt_reg - CNT_ONE;
                        err_reg <= mem_err;
                        mem_we_reg <= 1'b0;
                        mem_addr_reg <= src_reg;
                        if (mem_err || ab_reg || cnt_reg == CNT_ONE) begin
                            mem_req_reg <= 1'b0;
                            st_reg <= S_WB;
                        end else begin
                            mem_req_reg <= 1'b1;
                            st_reg <= S_RD;
                        end
                    end
                end
                S_WB: begin
                    if (!mem_req_reg) begin
                        mem_req_reg <= 1'b1;
                        mem_we_reg <= 1'b1;
                        mem_size_reg <= BEAT_WORD;
                        mem_addr_reg <= ch_addr(wb_base_reg, cur_reg);
                        mem_wdata_reg <= {cnt_reg, ctrl_reg[15:1], 1'b0};
                    end else if (mem_ack) begin
                        mem_req_reg <= 1'b0;
                        mem_we_reg <= 1'b0;
                        st_reg <= S_FIN;
                    end
                end
                S_FIN: begin
                    if (!err_reg && !ab_reg && !act[1] && !last) begin
                        daddr_reg <= nxt_reg;
                        mem_addr_reg <= nxt_reg;
                        mem_size_reg <= BEAT_WORD;
                        mem_req_reg <= 1'b1;
                        wcnt_reg <= 2'h0;
                        st_reg <= S_FETCH;
                    end else begin
                        st_reg <= S_IDLE;
                    end
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // busy map and event strobes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_reg <= NONE;
            evt_reg <= NONE;
        end else begin
            busy_reg <= (st_reg == S_IDLE) ? NONE : cur_1h;
            evt_reg <= NONE;
            if (st_reg == S_WR && mem_ack && !mem_err && evo == EVO_BEAT) begin
                evt_reg <= cur_1h;
            end else if (fin && !err_reg && !ab_reg && evo == EVO_BLOCK) begin
                evt_reg <= cur_1h;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign mem_req = mem_req_reg;
    assign mem_we = mem_we_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign mem_size = mem_size_reg;
    assign evt_strobe = evt_reg;
    assign busy_channel_map = busy_reg;
    assign irq = irq_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_irq_follows_pend: assert property (irq_reg == |pend_reg)
        else $error("irq differs from pending map");
    a_pend_masked_off: assert property (
        (done_msk_reg == NONE && err_msk_reg == NONE && susp_msk_reg == NONE)
        |=> pend_reg == NONE)
        else $error("pending bit set with all masks off");
    a_beat_size_used: assert property (
        (st_reg == S_RD || st_reg == S_WR) && mem_req_reg |-> mem_size_reg == bsz)
        else $error("beat size differs from descriptor");
    a_last_disables: assert property (
        fin && !err_reg && !ab_reg && !act[1] && last
        |=> !en_reg[$past(cur_reg)] && st_reg == S_IDLE)
        else $error("channel still enabled after last block");
    a_action_suspends: assert property (
        fin && !err_reg && !ab_reg && act[1]
        |=> susp_reg[$past(cur_reg)] && susp_flg_reg[$past(cur_reg)])
        else $error("suspend action did not suspend");
    a_beat_event: assert property (
        st_reg == S_WR && mem_ack && !mem_err && evo == EVO_BEAT
        |=> evt_reg == $past(cur_1h))
        else $error("missing beat event strobe");
    a_invalid_suspend: assert property (
        bad_desc |=> st_reg == S_IDLE && susp_reg[$past(cur_reg)])
        else $error("invalid descriptor not suspended");
    a_wb_valid_clear: assert property (
        st_reg == S_WB && mem_req_reg |-> mem_we_reg && !mem_wdata_reg[F_VALID]
        && mem_addr_reg == ch_addr(wb_base_reg, cur_reg))
        else $error("write-back keeps valid or wrong address");
    a_src_step: assert property (
        st_reg == S_RD && mem_ack
        |=> src_reg == $past(src_reg) + ($past(ctrl_reg[F_SRCINC]) ?
        beat_bytes($past(bsz)) : RESET_WORD))
        else $error("source address step wrong");
    a_busy_onehot: assert property ($onehot0(busy_reg))
        else $error("busy map has more than one bit");
    a_busy_current: assert property (
        st_reg != S_IDLE ##1 st_reg != S_IDLE |-> busy_reg == cur_1h)
        else $error("busy map wrong");
endmodule : dmadc_top

// [dmadc_pkg.sv]
// constants, register map and descriptor layout of the dma descriptor channel block
// assumes a single system clock; used by dmadc_top
// Behaviour
// - twelve pending-interrupt bits, one per channel, set while a flag and its mask bit are both one
// - a pending bit clears when its interrupts are masked or its flags cleared
// - beat-width field sets every data read and write access size: 8, 16, 32 bits; descriptor fetch and write-back use 32 bits
// - end actions 0 and 1 disable the channel after its last block; 1 interrupts
// - end action 2 suspends the channel; action 3 suspends and interrupts
// - event strobe: none for 0, per block for 1, per beat for 3
// - fetching a descriptor whose valid bit is zero suspends the channel
// - write-back copy valid bit cleared on abort, data read or write error, or block completion; a fetch error skips write-back
// - source address steps after each beat when source-increment is one
// - descriptor word 0 sits at base plus channel number times 0x10
package dmadc_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] OFF_CH_EN = 8'h00;
    localparam logic [7:0] OFF_SUSPENDED = 8'h04;
    localparam logic [7:0] OFF_ABORT = 8'h08;
    localparam logic [7:0] OFF_RESUME = 8'h0C;
    localparam logic [7:0] OFF_DONE_FLG = 8'h10;
    localparam logic [7:0] OFF_ERR_FLG = 8'h14;
    localparam logic [7:0] OFF_SUSP_FLG = 8'h18;
    localparam logic [7:0] OFF_DONE_MSK = 8'h1C;
    localparam logic [7:0] OFF_ERR_MSK = 8'h20;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFF_BUSY = 8'h28;
    localparam logic [7:0] OFF_SUSP_MSK = 8'h2C;
    localparam logic [7:0] OFF_DESC_BASE = 8'h30;
    localparam logic [7:0] OFF_WB_BASE = 8'h34;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // ==========================================================
    // descriptor word 0 fields and descriptor word layout
    localparam int F_VALID = 0;
    localparam int F_EVO = 1;
    localparam int F_ACT = 3;
    localparam int F_BEAT = 8;
    localparam int F_SRCINC = 10;
    localparam int F_DSTINC = 11;
    localparam int F_CNT = 16;
    localparam logic [31:0] CH_STRIDE = 32'h0000_0010;
    localparam logic [31:0] DW_SRC = 32'h0000_0004;
    localparam logic [31:0] DW_DST = 32'h0000_0008;
    localparam logic [31:0] DW_NEXT = 32'h0000_000C;
    localparam logic [1:0] W_LAST = 2'h3;
    // ==========================================================
    // codes
    localparam logic [1:0] BEAT_BYTE = 2'h0;
    localparam logic [1:0] BEAT_HALFWORD = 2'h1;
    localparam logic [1:0] BEAT_WORD = 2'h2;
    localparam logic [1:0] ACT_NO_ACTION = 2'h0;
    localparam logic [1:0] ACT_INT = 2'h1;
    localparam logic [1:0] ACT_SUSPEND = 2'h2;
    localparam logic [1:0] ACT_BOTH = 2'h3;
    localparam logic [1:0] EVO_OFF = 2'h0;
    localparam logic [1:0] EVO_BLOCK = 2'h1;
    localparam logic [1:0] EVO_BEAT = 2'h3;
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_FETCH = 6'h02,
        S_RD = 6'h04,
        S_WR = 6'h08,
        S_WB = 6'h10,
        S_FIN = 6'h20
    } dmadc_state_t;
endpackage : dmadc_pkg

// [dmadc_mem.sv]
// behavioural memory on the far side of the dma master port
// assumes one request at a time; answers after a two-cycle stall
`timescale 1ns/100ps
module dmadc_mem (
    input wire logic clk_sys,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [0:255];
    int wait_cnt = 0;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0000_0000;
    end
    // ==========================================================
    // read data is only meaningful with the ack; it toggles otherwise
    always @(posedge clk_sys) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req === 1'b1 && !mem_ack) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == 2) begin
                wait_cnt <= 0;
                mem_ack <= 1'b1;
                if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
                else mem_rdata <= mem[mem_addr[9:2]];
            end
        end
    end
endmodule : dmadc_mem

// [dma_descriptor_channel_status_bench.sv]
// self-checking bench: apb master, memory model, read results checked from a queue
// assumes apb slave with pready and memory master as in the design's header
`timescale 1ns/100ps
module dma_descriptor_channel_status_bench;
    import dmadc_pkg::*;
    logic clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, mem_addr, mem_wdata, mem_rdata, d0;
    logic [31:0] rnd = 32'h0000_3B86;
    logic pready, pslverr, mem_req, mem_we, mem_ack, irq, mem_err = 1'b0;
    logic [1:0] mem_size;
    logic [11:0] evt_strobe, busy_channel_map;
    logic [11:0] exp_ch = 12'h000;
    logic [31:0] expq [$];
    int num_errors = 0, n_tests = 0, n_evt = 0;
    dmadc_top u_dmadc_top (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_size,
        .mem_ack, .mem_err, .mem_rdata, .evt_strobe, .busy_channel_map, .irq);
    dmadc_mem u_dmadc_mem (.clk_sys, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
        .mem_rdata);
    always #50 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        if (!wr) expq.push_back(d);
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    // ==========================================================
    // result watcher: read data is compared with the oldest note
    always @(posedge clk_sys) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            check({31'h0, pslverr}, {31'h0, paddr > OFF_WB_BASE});
            if (pwrite === 1'b0) check(prdata, expq.pop_front());
        end
        if (mem_req === 1'b1 && mem_ack === 1'b1) begin
            check({30'h0, mem_size}, {30'h0, BEAT_WORD});
            check({20'h0, busy_channel_map}, {20'h0, exp_ch});
        end
        if (evt_strobe[0] === 1'b1) n_evt++;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        finish_test();
    end
    initial begin
        rnd = xs(rnd);
        d0 = {16'h0002, 4'h0, 1'b1, 1'b1, BEAT_WORD, 3'h0, ACT_INT, EVO_BLOCK, 1'b1};
        u_dmadc_mem.mem[0] = d0;
        u_dmadc_mem.mem[1] = 32'h0000_0080;
        u_dmadc_mem.mem[2] = 32'h0000_00C0;
        u_dmadc_mem.mem[3] = 32'h0000_0000;
        u_dmadc_mem.mem[4] = 32'h0000_0000;
        u_dmadc_mem.mem[32] = rnd;
        u_dmadc_mem.mem[33] = xs(rnd);
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        apb(1'b0, OFF_BUSY, 32'h0000_0000);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0000_0000);
        apb(1'b0, 8'h3C, 32'h0000_0000);
        apb(1'b1, OFF_WB_BASE, 32'h0000_0100);
        apb(1'b1, OFF_DONE_MSK, 32'h0000_0001);
        exp_ch = 12'h001;
        apb(1'b1, OFF_CH_EN, 32'h0000_0001);
        for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clk_sys);
        check(u_dmadc_mem.mem[48], rnd);
        check(u_dmadc_mem.mem[49], xs(rnd));
        check(u_dmadc_mem.mem[64], {16'h0000, d0[15:1], 1'b0});
        check(32'(n_evt), 32'h0000_0001);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0000_0001);
        apb(1'b0, OFF_BUSY, 32'h0000_0000);
        apb(1'b1, OFF_DONE_FLG, 32'h0000_0001);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        exp_ch = 12'h002;
        apb(1'b1, OFF_CH_EN, 32'h0000_0002);
        repeat (60) @(posedge clk_sys);
        apb(1'b0, OFF_SUSPENDED, 32'h0000_0002);
        finish_test();
    end
endmodule : dma_descriptor_channel_status_bench
